/* File: rtl/pts_pkg.sv */
// package for the period timer: register map, field layout, reset values, bus carriers
// How it works
// - count ticks from osc/4 through prescaler
// - count up, wrap to zero after period
// - period register read/write, resets to ffh
// - count register read/write, resets to zero
// - postscaler divides matches by field plus one
// - postscaler output sets sticky match flag
// - run bit low stops the timer
// - count/control write or reset clears scalers
// - control write leaves the count alone
package pts_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam int          IDX_W       = 10;
  localparam logic [9:0]  IDX_IRQCTL  = 10'h00b;
  localparam logic [9:0]  IDX_FLAGS   = 10'h00c;
  localparam logic [9:0]  IDX_CLEAR   = 10'h00d;
  localparam logic [9:0]  IDX_COUNT   = 10'h011;
  localparam logic [9:0]  IDX_CONTROL = 10'h012;
  localparam logic [9:0]  IDX_ENABLES = 10'h08c;
  localparam logic [9:0]  IDX_PERIOD  = 10'h092;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          FLAG_POS    = 1;
  localparam int          PERIPHERAL_IRQ_EN_POS    = 6;
  localparam int          GIE_POS     = 7;
  localparam logic [7:0]  COUNT_RST   = 8'h00;
  localparam logic [7:0]  PERIOD_RST  = 8'hff;
  localparam logic [7:0]  CONTROL_RST = 8'h00;

  // ---------------------------------------------------------------
  // timing: instruction clock is the oscillator over four
  // ---------------------------------------------------------------
  localparam int          OSC_PER_INSTR = 4;
  localparam int          PRE_W         = 6;
  localparam logic [5:0]  PRE_LIM_1     = 6'(OSC_PER_INSTR * 1 - 1);
  localparam logic [5:0]  PRE_LIM_4     = 6'(OSC_PER_INSTR * 4 - 1);
  localparam logic [5:0]  PRE_LIM_16    = 6'(OSC_PER_INSTR * 16 - 1);

  typedef struct packed {
    logic       unused;
    logic [3:0] postscale_select;
    logic       timer_run;
    logic [1:0] prescale_select;
  } pts_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic [9:0] idx;
    logic [7:0] wdata;
  } pts_req_t;

  function automatic logic pts_mapped(input logic [9:0] idx);
    return idx inside {IDX_IRQCTL, IDX_FLAGS, IDX_CLEAR, IDX_COUNT, IDX_CONTROL, IDX_ENABLES, IDX_PERIOD};
  endfunction

  function automatic logic [5:0] pts_pre_limit(input logic [1:0] sel);
    return sel[1] ? PRE_LIM_16 : (sel[0] ? PRE_LIM_4 : PRE_LIM_1);
  endfunction

endpackage

/* File: rtl/pts_scaler.sv */
// wrap-around tick divider shared by the prescaler and the postscaler
`timescale 1ns/1ps
module pts_scaler
  import pts_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         clear_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] limit_i,
  output logic              done_o
);

  logic [W-1:0] cnt;

  if (W < 1) begin : g_chk
    $error("pts_scaler: width must be at least one");
  end

  assign done_o = tick_i && (cnt == limit_i);

  // clear beats tick so a write restarts the ratio cleanly
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (clear_i) begin
      cnt <= '0;
    end else if (tick_i) begin
      cnt <= done_o ? '0 : W'(cnt + 1'b1);
    end
  end

endmodule

/* File: rtl/pts_apb.sv */
// apb slave front end: decode, zero-wait answer, registered read data
`timescale 1ns/1ps
module pts_apb
  import pts_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [7:0]        rdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  output pts_req_t               req_o
);

  logic setup;
  logic ok;

  assign setup = psel_i && !penable_i && !pready_o;
  assign ok    = pts_mapped(paddr_i[ADDR_W-1:2]) && (paddr_i[1:0] == 2'b00);

  // answer prepared at the setup edge, so the access phase ends after one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      prdata_o  <= (setup && !pwrite_i && ok) ? {24'h00_0000, rdata_i} : 32'h0000_0000;
      pslverr_o <= setup && !ok;
    end
  end

  assign req_o.wr    = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  assign req_o.idx   = paddr_i[ADDR_W-1:2];
  assign req_o.wdata = pwdata_i[7:0];

endmodule

/* File: rtl/pts_timer.sv */
// period timer top: count, period, control, match flag, interrupt and apb registers
`timescale 1ns/1ps
module pts_timer
  import pts_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  output logic                   match_o,
  output logic                   irq_o
);

  if (CNT_W != 8) begin : g_chk
    $error("pts_timer: registers are eight bits wide");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pts_req_t   req;
  pts_ctrl_t  ctrl;
  logic [7:0] count;
  logic [7:0] period;
  logic       timer_match_flag;
  logic       timer_match_irq_en;
  logic       peripheral_irq_en;
  logic       global_irq_en;
  logic [7:0] rdata;
  logic       cnt_wr;
  logic       ctl_wr;
  logic       clr_wr;
  logic       scaler_clear;
  logic       inc_tick;
  logic       match;
  logic       post_done;

  assign cnt_wr       = req.wr && (req.idx == IDX_COUNT);
  assign ctl_wr       = req.wr && (req.idx == IDX_CONTROL);
  assign clr_wr       = req.wr && (req.idx == IDX_CLEAR) && req.wdata[FLAG_POS];
  assign scaler_clear = cnt_wr || ctl_wr;

  pts_apb u_apb (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .rdata_i   (rdata),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .req_o     (req)
  );

  // ---------------------------------------------------------------
  // prescaler: osc/4 folded in, so limits are 4, 16 or 64 clocks
  // ---------------------------------------------------------------
  pts_scaler #(.W(PRE_W)) u_pre (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (scaler_clear),
    .tick_i  (ctrl.timer_run),
    .limit_i (pts_pre_limit(ctrl.prescale_select)),
    .done_o  (inc_tick)
  );

  // a count write in the same cycle wins over the wrap
  assign match = inc_tick && !cnt_wr && (count == period);

  pts_scaler #(.W(4)) u_post (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (scaler_clear),
    .tick_i  (match),
    .limit_i (ctrl.postscale_select),
    .done_o  (post_done)
  );

  // ---------------------------------------------------------------
  // count and period
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= COUNT_RST;
    end else if (cnt_wr) begin
      count <= req.wdata;
    end else if (match) begin
      count <= 8'h00;
    end else if (inc_tick) begin
      count <= 8'(count + 8'h01);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      period <= PERIOD_RST;
    end else if (req.wr && req.idx == IDX_PERIOD) begin
      period <= req.wdata;
    end
  end

  // control write never touches count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CONTROL_RST;
    end else if (ctl_wr) begin
      ctrl <= {1'b0, req.wdata[6:0]};
    end
  end

  // ---------------------------------------------------------------
  // flag, enables, interrupt
  // ---------------------------------------------------------------
  // hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_match_flag <= 1'b0;
    end else if (post_done) begin
      timer_match_flag <= 1'b1;
    end else if (clr_wr) begin
      timer_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_match_irq_en <= 1'b0;
      peripheral_irq_en  <= 1'b0;
      global_irq_en      <= 1'b0;
    end else if (req.wr && req.idx == IDX_ENABLES) begin
      timer_match_irq_en <= req.wdata[FLAG_POS];
    end else if (req.wr && req.idx == IDX_IRQCTL) begin
      peripheral_irq_en <= req.wdata[PERIPHERAL_IRQ_EN_POS];
      global_irq_en     <= req.wdata[GIE_POS];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o   <= 1'b0;
      match_o <= 1'b0;
    end else begin
      irq_o   <= timer_match_flag && timer_match_irq_en && peripheral_irq_en && global_irq_en;
      match_o <= match;
    end
  end

  // ---------------------------------------------------------------
  // read mux; clear register reads as zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata = 8'h00;
    unique case (req.idx)
      IDX_COUNT:   rdata = count;
      IDX_PERIOD:  rdata = period;
      IDX_CONTROL: rdata = {1'b0, ctrl[6:0]};
      IDX_FLAGS:   rdata[FLAG_POS] = timer_match_flag;
      IDX_ENABLES: rdata[FLAG_POS] = timer_match_irq_en;
      IDX_IRQCTL:  rdata = {global_irq_en, peripheral_irq_en, 6'h00};
      default:     rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [PRE_W-1:0] gap;
  logic [3:0]       seen;

  // cycles since the last increment, restarted by anything that restarts the prescaler
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= '0;
    end else if (inc_tick || scaler_clear || !ctrl.timer_run) begin
      gap <= '0;
    end else begin
      gap <= PRE_W'(gap + 1'b1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen <= 4'h0;
    end else if (post_done || scaler_clear) begin
      seen <= 4'h0;
    end else if (match) begin
      seen <= 4'(seen + 4'h1);
    end
  end

  sequence s_scaler_write;
    cnt_wr || ctl_wr;
  endsequence

  sequence s_quiet_prescaler;
    !inc_tick [*3];
  endsequence

  chk_prescale_gap: assert property (inc_tick |-> gap == pts_pre_limit(ctrl.prescale_select))
    else $error("increment came at the wrong prescale gap");
  chk_prescale_sixteen: assert property (ctrl.prescale_select[1] && inc_tick |-> gap == 6'h3f)
    else $error("upper select bit did not give divide by sixteen");
  chk_count_wrap: assert property (match |=> count == 8'h00)
    else $error("count did not wrap after period match");
  chk_count_step: assert property (inc_tick && !cnt_wr && count != period |=> count == 8'($past(count) + 8'h01))
    else $error("count did not step by one");
  chk_period_write: assert property (req.wr && req.idx == IDX_PERIOD |=> period == $past(req.wdata))
    else $error("period write not stored");
  chk_count_write: assert property (cnt_wr |=> count == $past(req.wdata))
    else $error("count write not stored");
  chk_post_ratio: assert property (post_done |-> seen == ctrl.postscale_select)
    else $error("postscaler fired at wrong match count");
  chk_flag_set: assert property (post_done |=> timer_match_flag [*2] or (timer_match_flag ##1 !timer_match_flag))
    else $error("postscaler output did not set flag");
  chk_flag_sticky: assert property (timer_match_flag && !clr_wr |=> timer_match_flag)
    else $error("flag dropped without a clear");
  chk_stop_hold: assert property (!ctrl.timer_run && !cnt_wr |=> count == $past(count))
    else $error("stopped timer changed count");
  chk_scaler_restart: assert property (s_scaler_write |=> s_quiet_prescaler)
    else $error("prescaler not restarted by write");
  chk_ctrl_keep_count: assert property (ctl_wr && !inc_tick |=> count == $past(count))
    else $error("control write disturbed count");
  chk_match_out: assert property (match |=> match_o ##1 !match_o || match)
    else $error("match output missing");
  chk_irq_gate: assert property (##1 irq_o == $past(timer_match_flag && timer_match_irq_en
                                   && peripheral_irq_en && global_irq_en))
    else $error("interrupt output not gated by enables");

endmodule

/* File: verif/pts_timer_tb.sv */
// self-checking bench for the period timer: registers, match rate, postscaler, interrupt
`timescale 1ns/1ps
module pts_timer_tb;
  import pts_pkg::*;

  // ---------------------------------------------------------------
  // signals and bookkeeping
  // ---------------------------------------------------------------
  logic              clk_i     = 1'b0;
  logic              rst_i     = 1'b1;
  logic              psel_i    = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i  = 1'b0;
  logic [ADDR_W-1:0] paddr_i   = '0;
  logic [31:0]       pwdata_i  = '0;
  logic              pready_o;
  logic [31:0]       prdata_o;
  logic              pslverr_o;
  logic              match_o;
  logic              irq_o;
  logic [31:0]       rd;
  logic [31:0]       er;
  logic [31:0]       seed      = 32'h72a3973f;
  int                n_errors  = 0;
  int                n_compared = 0;
  int                cyc       = 0;
  int                last_m    = 0;
  int                gap       = 0;
  int                n_match   = 0;

  pts_timer #(.CNT_W(8)) DUT (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .match_o   (match_o),
    .irq_o     (irq_o)
  );

  // ---------------------------------------------------------------
  // clock, timeout and match monitor
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ceiling well above the few thousand cycles the sequence needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      end_sim();
    end
  end

  // looked at mid-cycle, since the pulse stands one cycle only
  always @(negedge clk_i) begin
    if (match_o === 1'b1) begin
      gap = cyc - last_m;
      last_m = cyc;
      n_match++;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [31:0] exp_gap(input int p, input int sel);
    return 32'((p + 1) * OSC_PER_INSTR * (sel >= 2 ? 16 : (sel == 1 ? 4 : 1)));
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is sampled high at a rising edge; answer taken at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      n_errors++;
      $display("unexpected pready expected 1 seen %b", pready_o);
    end
    rd = prdata_o;
    er = 32'(pslverr_o);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_match(input int k);
    int base;
    base = n_match;
    for (int i = 0; i < 5000 && n_match < base + k; i++) @(negedge clk_i);
    if (n_match < base + k) begin
      n_errors++;
      $display("unexpected match count expected %0d seen %0d", base + k, n_match);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int p;
    int pre;
    int post;
    int v;
    int base;
    int i;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, ba(IDX_COUNT), 32'h0);   chk("count reset", 32'h00, rd);
    apb(1'b0, ba(IDX_PERIOD), 32'h0);  chk("period reset", 32'hff, rd);
    apb(1'b0, ba(IDX_CONTROL), 32'h0); chk("control reset", 32'h00, rd);
    apb(1'b0, ba(IDX_ENABLES), 32'h0); chk("enables reset", 32'h00, rd);
    apb(1'b1, ba(IDX_FLAGS), 32'hff);  chk("flags write err", 32'h0, er);
    apb(1'b0, ba(IDX_FLAGS), 32'h0);   chk("flags read only", 32'h00, rd);
    apb(1'b0, 12'hffc, 32'h0);         chk("unmapped err", 32'h1, er);
    apb(1'b1, ba(IDX_COUNT) | 12'h1, 32'h33); chk("misaligned err", 32'h1, er);
    apb(1'b0, ba(IDX_COUNT), 32'h0);   chk("count after refusal", 32'h00, rd);
    // every prescale code, random small periods
    for (pre = 0; pre < 4; pre++) begin
      p = int'(rnd() & 32'h7) | 1;
      apb(1'b1, ba(IDX_PERIOD), 32'(p));
      apb(1'b0, ba(IDX_PERIOD), 32'h0); chk("period readback", 32'(p), rd);
      apb(1'b1, ba(IDX_COUNT), 32'h0);
      apb(1'b1, ba(IDX_CONTROL), 32'h4 | 32'(pre));
      wait_match(3);
      chk("match gap", exp_gap(p, pre), 32'(gap));
      apb(1'b1, ba(IDX_CONTROL), 32'h0);
      apb(1'b0, ba(IDX_FLAGS), 32'h0);   chk("flag set", 32'h2, rd);
      chk("irq masked", 32'h0, 32'(irq_o));
      apb(1'b1, ba(IDX_CLEAR), 32'h2);
      apb(1'b0, ba(IDX_FLAGS), 32'h0);   chk("flag cleared", 32'h0, rd);
    end
    // postscaler ratios with the interrupt enabled; last pass restarts mid-way
    apb(1'b1, ba(IDX_ENABLES), 32'h2);
    apb(1'b1, ba(IDX_IRQCTL), 32'hc0);
    apb(1'b1, ba(IDX_PERIOD), 32'h7);
    for (v = 0; v < 4; v++) begin
      post = (v == 0) ? 0 : ((v == 1) ? 15 : (int'(rnd() & 32'hf) | 1));
      apb(1'b1, ba(IDX_COUNT), 32'h0);
      apb(1'b1, ba(IDX_CONTROL), 32'h4 | 32'(post << 3));
      if (v == 3) begin
        // a control write must throw away the match already counted
        wait_match(1);
        apb(1'b1, ba(IDX_CONTROL), 32'h4 | 32'(post << 3));
      end
      base = n_match;
      for (i = 0; i < 2000 && irq_o !== 1'b1; i++) @(negedge clk_i);
      chk("matches per flag", 32'(post + 1), 32'(n_match - base));
      apb(1'b1, ba(IDX_CONTROL), 32'h0);
      apb(1'b1, ba(IDX_IRQCTL), 32'h40);
      repeat (2) @(negedge clk_i);
      chk("irq global off", 32'h0, 32'(irq_o));
      apb(1'b1, ba(IDX_IRQCTL), 32'hc0);
      repeat (2) @(negedge clk_i);
      chk("irq enabled", 32'h1, 32'(irq_o));
      apb(1'b1, ba(IDX_CLEAR), 32'h2);
      repeat (2) @(negedge clk_i);
      chk("irq after clear", 32'h0, 32'(irq_o));
    end
    // stopped timer holds, control write keeps the count
    v = int'(rnd() & 32'hff);
    p = int'(rnd() & 32'h7b);
    apb(1'b1, ba(IDX_COUNT), 32'(v));
    apb(1'b1, ba(IDX_CONTROL), 32'(p));
    repeat (200) @(posedge clk_i);
    apb(1'b0, ba(IDX_COUNT), 32'h0);   chk("count held", 32'(v), rd);
    apb(1'b0, ba(IDX_CONTROL), 32'h0); chk("control readback", 32'(p), rd);
    end_sim();
  end
endmodule
